// File: hdl/cie_pkg.sv
package cie_pkg;
    // ------------------------------------------------------------
    // reset values, fixed addresses and synchroniser bit positions
    // ------------------------------------------------------------
    localparam logic [15:0] CIE_PC_RESET     = 16'h0000;
    localparam logic [15:0] CIE_NMI_VECTOR   = 16'h0066;
    localparam logic [7:0]  CIE_VPAGE_RESET  = 8'h00;
    localparam logic [7:0]  CIE_REFRESH_RESET = 8'h00;
    localparam logic [1:0]  CIE_IM_RESET     = 2'h0;
    localparam int          CIE_SYNC_BITS    = 4;
    localparam int          CIE_SYNC_WAIT    = 0;
    localparam int          CIE_SYNC_IRQ     = 1;
    localparam int          CIE_SYNC_NMI     = 2;
    localparam int          CIE_SYNC_BUSREQ  = 3;

    // ------------------------------------------------------------
    // bus ownership states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CIE_BUS_OWN,
        CIE_BUS_FLOAT,
        CIE_BUS_GRANT
    } cie_bus_state_type;
endpackage

// File: hdl/cie_sync_if.sv
interface cie_sync_if;
    logic [3:0] pins_n;
    modport src (output pins_n);
    modport dst (input  pins_n);
endinterface

// File: hdl/cie_input_sync.sv
module cie_input_sync
    import cie_pkg::*;
(
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    input  wire logic [CIE_SYNC_BITS-1:0] raw_n,
    cie_sync_if.src                       sync
);
    // ------------------------------------------------------------
    // two-flop synchronisers, idle high
    // ------------------------------------------------------------
    logic [CIE_SYNC_BITS-1:0] meta_reg;
    logic [CIE_SYNC_BITS-1:0] stable_reg;

    genvar i;
    generate
        for (i = 0; i < CIE_SYNC_BITS; i++) begin : g_bit
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    meta_reg[i]   <= 1'b1;
                    stable_reg[i] <= 1'b1;
                end else begin
                    meta_reg[i]   <= raw_n[i];
                    stable_reg[i] <= meta_reg[i];
                end
            end
        end
    endgenerate

    assign sync.pins_n = stable_reg;
endmodule

// File: hdl/cie_exception_ctrl.sv
// Summary of operation
// - wait low stalls transfer until high
// - irq taken at end, enabled, no busreq
// - acknowledge with io strobe plus fetch
// - nmi falling edge, beats irq, unmasked
// - nmi continues at address 0066
// - nmi pushes current program counter
// - bus request beats nmi; waits delay
// - reset clears program counter
// - reset clears enable, page, refresh, mode
// - reset floats buses, controls inactive
// - bus request floats after machine cycle
// - acknowledge only once outputs float
// - io strobe with fetch only for ack
module cie_exception_ctrl
    import cie_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wait_pin_n,
    input  wire logic        irq_pin_n,
    input  wire logic        nmi_pin_n,
    input  wire logic        bus_release_req_n,
    input  wire logic        core_cycle_end,
    input  wire logic        core_instr_end,
    input  wire logic        core_pc_inc,
    input  wire logic        core_pc_load,
    input  wire logic [15:0] core_pc_value,
    input  wire logic        core_ei,
    input  wire logic        core_di,
    input  wire logic        core_im_set,
    input  wire logic [1:0]  core_im_value,
    input  wire logic        core_vpage_load,
    input  wire logic [7:0]  core_vpage_value,
    input  wire logic        core_refresh_inc,
    input  wire logic [15:0] core_addr,
    input  wire logic        core_addr_en,
    input  wire logic [7:0]  core_data,
    input  wire logic        core_data_en,
    input  wire logic        core_mreq,
    input  wire logic        core_io_request_strobe_n,
    input  wire logic        core_rd,
    input  wire logic        core_wr,
    input  wire logic        core_m1,
    output logic             core_stall,
    output logic             nmi_taken,
    output logic             irq_taken,
    output logic [15:0]      push_pc,
    output logic [15:0]      pc,
    output logic             irq_enable_flop,
    output logic [7:0]       vector_page,
    output logic [7:0]       refresh_count,
    output logic [1:0]       irq_mode,
    output logic [15:0]      addr_out,
    output logic             addr_oe,
    output logic [7:0]       data_out,
    output logic             data_oe,
    output logic             mreq_n,
    output logic             io_request_strobe_n,
    output logic             rd_n,
    output logic             wr_n,
    output logic             ctrl_oe,
    output logic             opcode_fetch_cycle_n,
    output logic             bus_release_ack_n
);
    import cie_pkg::*;

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    cie_sync_if sync_bus ();

    cie_input_sync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .raw_n ({bus_release_req_n, nmi_pin_n, irq_pin_n, wait_pin_n}),
        .sync  (sync_bus.src)
    );

    logic wait_ok;
    logic irq_req;
    logic nmi_s;
    logic busreq;

    assign wait_ok = sync_bus.pins_n[CIE_SYNC_WAIT];
    assign irq_req = !sync_bus.pins_n[CIE_SYNC_IRQ];
    assign nmi_s   = sync_bus.pins_n[CIE_SYNC_NMI];
    assign busreq  = !sync_bus.pins_n[CIE_SYNC_BUSREQ];

    // ------------------------------------------------------------
    // boundaries, gated by wait
    // ------------------------------------------------------------
    cie_bus_state_type bus_state_reg;
    logic              cycle_done;
    logic              instr_done;
    logic              take_nmi;
    logic              take_irq;
    logic              nmi_prev_reg;
    logic              nmi_pend_reg;
    logic              ack_pend_reg;
    logic              ack_active_reg;

    // a boundary cannot pass while the transfer is stretched
    assign cycle_done = core_cycle_end && wait_ok;
    assign instr_done = core_instr_end && wait_ok && bus_state_reg == CIE_BUS_OWN;
    assign take_nmi   = instr_done && nmi_pend_reg && !busreq;
    assign take_irq   = instr_done && !take_nmi && irq_req && irq_enable_flop && !busreq;
    assign core_stall = !wait_ok || bus_state_reg != CIE_BUS_OWN;

    // ------------------------------------------------------------
    // nmi edge capture
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            nmi_prev_reg <= 1'b1;
            nmi_pend_reg <= 1'b0;
        end else begin
            nmi_prev_reg <= nmi_s;
            // a new edge in the taking cycle wins over the clear
            if (nmi_prev_reg && !nmi_s) begin
                nmi_pend_reg <= 1'b1;
            end else if (take_nmi) begin
                nmi_pend_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // program counter and push
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pc        <= CIE_PC_RESET;
            push_pc   <= CIE_PC_RESET;
            nmi_taken <= 1'b0;
            irq_taken <= 1'b0;
        end else begin
            nmi_taken <= take_nmi;
            irq_taken <= take_irq;
            if (take_nmi) begin
                push_pc <= pc;
                pc      <= CIE_NMI_VECTOR;
            end else if (take_irq) begin
                push_pc <= pc;
            end else if (core_pc_load) begin
                pc <= core_pc_value;
            end else if (core_pc_inc) begin
                pc <= pc + 16'h0001;
            end
        end
    end

    // ------------------------------------------------------------
    // processor state registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_enable_flop <= 1'b0;
            vector_page     <= CIE_VPAGE_RESET;
            refresh_count   <= CIE_REFRESH_RESET;
            irq_mode        <= CIE_IM_RESET;
        end else begin
            // taking any interrupt closes the mask
            if (take_nmi || take_irq) begin
                irq_enable_flop <= 1'b0;
            end else if (core_ei) begin
                irq_enable_flop <= 1'b1;
            end else if (core_di) begin
                irq_enable_flop <= 1'b0;
            end
            if (core_im_set) begin
                irq_mode <= core_im_value;
            end
            if (core_vpage_load) begin
                vector_page <= core_vpage_value;
            end
            if (core_refresh_inc) begin
                refresh_count <= {refresh_count[7], refresh_count[6:0] + 7'h01};
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt acknowledge cycle
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_pend_reg   <= 1'b0;
            ack_active_reg <= 1'b0;
        end else begin
            if (take_irq) begin
                ack_pend_reg <= 1'b1;
            end else if (ack_pend_reg) begin
                ack_pend_reg   <= 1'b0;
                ack_active_reg <= 1'b1;
            end else if (ack_active_reg && cycle_done) begin
                ack_active_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // bus release
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bus_state_reg <= CIE_BUS_OWN;
        end else begin
            case (bus_state_reg)
                CIE_BUS_OWN: begin
                    if (busreq && cycle_done && !ack_pend_reg && !ack_active_reg) begin
                        bus_state_reg <= CIE_BUS_FLOAT;
                    end
                end
                CIE_BUS_FLOAT: begin
                    if (busreq) begin
                        bus_state_reg <= CIE_BUS_GRANT;
                    end else begin
                        bus_state_reg <= CIE_BUS_OWN;
                    end
                end
                CIE_BUS_GRANT: begin
                    if (!busreq) begin
                        bus_state_reg <= CIE_BUS_OWN;
                    end
                end
                default: begin
                    bus_state_reg <= CIE_BUS_OWN;
                end
            endcase
        end
    end

    // acknowledge only from a state entered after drives are off
    assign bus_release_ack_n = bus_state_reg != CIE_BUS_GRANT;

    // ------------------------------------------------------------
    // pin drivers, registered
    // ------------------------------------------------------------
    logic drive_next;

    // float decision uses the next state so drives drop with it
    assign drive_next = bus_state_reg == CIE_BUS_OWN
                        && !(busreq && cycle_done && !ack_pend_reg && !ack_active_reg);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            addr_out             <= 16'h0000;
            addr_oe              <= 1'b0;
            data_out             <= 8'h00;
            data_oe              <= 1'b0;
            ctrl_oe              <= 1'b0;
            mreq_n               <= 1'b1;
            io_request_strobe_n  <= 1'b1;
            rd_n                 <= 1'b1;
            wr_n                 <= 1'b1;
            opcode_fetch_cycle_n <= 1'b1;
        end else begin
            addr_out <= core_addr;
            data_out <= core_data;
            addr_oe  <= drive_next && core_addr_en;
            data_oe  <= drive_next && core_data_en;
            ctrl_oe  <= drive_next;
            mreq_n   <= !(drive_next && core_mreq && !ack_active_reg);
            rd_n     <= !(drive_next && core_rd && !ack_active_reg);
            wr_n     <= !(drive_next && core_wr && !ack_active_reg);
            // ordinary io is never let through during a fetch cycle
            io_request_strobe_n  <= !(drive_next
                                      && (ack_active_reg || (core_io_request_strobe_n && !core_m1)));
            opcode_fetch_cycle_n <= !(ack_active_reg || (drive_next && core_m1));
        end
    end
endmodule

// File: testbench/cie_exception_ctrl_checker.sv
// ------------------------------------------------------------
// port checker for the exception control block
// ------------------------------------------------------------
module cie_ctrl_checker
    import cie_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        wait_pin_n,
    input wire logic        core_stall,
    input wire logic        nmi_taken,
    input wire logic        irq_taken,
    input wire logic [15:0] push_pc,
    input wire logic [15:0] pc,
    input wire logic        irq_enable_flop,
    input wire logic        addr_oe,
    input wire logic        data_oe,
    input wire logic        ctrl_oe,
    input wire logic        mreq_n,
    input wire logic        io_request_strobe_n,
    input wire logic        rd_n,
    input wire logic        opcode_fetch_cycle_n,
    input wire logic        bus_release_ack_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_reset_regs_clear: assert property ($rose(rst_n) |-> pc == 16'h0000 && !irq_enable_flop)
        else $error("state not cleared by reset");
    a_reset_bus_idle: assert property ($rose(rst_n) |-> !(addr_oe || data_oe || ctrl_oe)
        && mreq_n && rd_n && io_request_strobe_n && opcode_fetch_cycle_n && bus_release_ack_n)
        else $error("bus not idle after reset");
    // two sync stages, so four low samples must already show
    a_wait_holds_stall: assert property (!wait_pin_n [*4] |-> core_stall)
        else $error("no stall while not ready");
    a_irq_ack_follows: assert property (irq_taken |-> ##[1:4]
        (!io_request_strobe_n && !opcode_fetch_cycle_n))
        else $error("no acknowledge after irq entry");
    a_ack_no_transfer: assert property ((!io_request_strobe_n && !opcode_fetch_cycle_n)
        |-> mreq_n && rd_n)
        else $error("transfer during acknowledge");
    a_nmi_vector_jump: assert property (nmi_taken |-> pc == 16'h0066)
        else $error("nmi entry not at fixed vector");
    a_nmi_saves_pc: assert property (nmi_taken |-> push_pc == $past(pc))
        else $error("pushed pc wrong");
    a_grant_means_float: assert property (!bus_release_ack_n |-> !(addr_oe || data_oe || ctrl_oe))
        else $error("grant while driving");
    a_grant_blocks_entry: assert property (!bus_release_ack_n |=> !nmi_taken && !irq_taken)
        else $error("entry while bus granted");
endmodule
bind cie_exception_ctrl cie_ctrl_checker i_cie_ctrl_checker (.clk, .rst_n, .wait_pin_n,
    .core_stall, .nmi_taken, .irq_taken, .push_pc, .pc, .irq_enable_flop, .addr_oe, .data_oe,
    .ctrl_oe, .mreq_n, .io_request_strobe_n, .rd_n, .opcode_fetch_cycle_n, .bus_release_ack_n);

// File: testbench/cie_far_side.sv
// ------------------------------------------------------------
// far side: slow memory, peripheral, bus master
// ------------------------------------------------------------
module cie_far_side (
    input wire logic       clk,
    input wire logic       slow_n,
    input wire logic [3:0] slow,
    input wire logic       irq_want,
    input wire logic       nmi_fire,
    input wire logic       bus_want,
    input wire logic       mreq_n,
    input wire logic       io_request_strobe_n,
    input wire logic       opcode_fetch_cycle_n,
    output logic           wait_pin_n,
    output logic           irq_pin_n,
    output logic           nmi_pin_n,
    output logic           bus_release_req_n
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] hold_reg;
    logic       mreq_reg;
    initial {hold_reg, mreq_reg, irq_pin_n, nmi_pin_n, bus_release_req_n} = 8'h0f;
    // pins move on the falling edge, clear of the sampling edge
    always @(negedge clk) begin
        mreq_reg <= mreq_n;
        if (mreq_reg && !mreq_n && slow_n) hold_reg <= slow;
        else if (hold_reg != 4'h0) hold_reg <= hold_reg - 4'h1;
        // level request, so it must stay low until the ack cycle
        irq_pin_n <= !irq_want || (!io_request_strobe_n && !opcode_fetch_cycle_n);
        nmi_pin_n <= !nmi_fire;
        // master only asks; it drives no line, so never before grant
        bus_release_req_n <= !bus_want;
    end
    assign wait_pin_n = hold_reg == 4'h0;
endmodule

// File: testbench/cie_exception_ctrl_bench.sv
// ------------------------------------------------------------
// bench: reset, wait, bus release, interrupt entry
// ------------------------------------------------------------
module cie_exception_ctrl_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst_n, core_cycle_end, core_instr_end, core_pc_inc, core_pc_load, core_ei;
    logic        core_di, core_im_set, core_vpage_load, core_refresh_inc, core_m1, core_addr_en;
    logic        core_data_en, core_mreq, core_io_request_strobe_n, core_rd, core_wr, wait_pin_n, irq_pin_n;
    logic        nmi_pin_n, bus_release_req_n, core_stall, nmi_taken, irq_taken, irq_enable_flop;
    logic        addr_oe, data_oe, ctrl_oe, mreq_n, io_request_strobe_n, rd_n, wr_n, got_nmi;
    logic        opcode_fetch_cycle_n, bus_release_ack_n, irq_want, nmi_fire, bus_want, got_irq;
    logic [15:0] core_pc_value, core_addr, pc, push_pc, addr_out;
    logic [7:0]  core_vpage_value, core_data, vector_page, refresh_count, data_out;
    logic [1:0]  core_im_value, irq_mode;
    logic [3:0]  slow;
    int          err_total = 0, cmp_count = 0, n;
    cie_exception_ctrl i_cie_exception_ctrl (.clk, .rst_n, .wait_pin_n, .irq_pin_n, .nmi_pin_n,
        .bus_release_req_n, .core_cycle_end, .core_instr_end, .core_pc_inc, .core_pc_load,
        .core_pc_value, .core_ei, .core_di, .core_im_set, .core_im_value, .core_vpage_load,
        .core_vpage_value, .core_refresh_inc, .core_addr, .core_addr_en, .core_data,
        .core_data_en, .core_mreq, .core_io_request_strobe_n, .core_rd, .core_wr, .core_m1, .core_stall,
        .nmi_taken, .irq_taken, .push_pc, .pc, .irq_enable_flop, .vector_page, .refresh_count,
        .irq_mode, .addr_out, .addr_oe, .data_out, .data_oe, .mreq_n, .io_request_strobe_n,
        .rd_n, .wr_n, .ctrl_oe, .opcode_fetch_cycle_n, .bus_release_ack_n);
    cie_far_side i_cie_far_side (.clk, .slow_n(rst_n), .slow, .irq_want, .nmi_fire, .bus_want,
        .mreq_n, .io_request_strobe_n, .opcode_fetch_cycle_n, .wait_pin_n, .irq_pin_n,
        .nmi_pin_n, .bus_release_req_n);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task check(input logic [39:0] seen, input logic [39:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // bounded, so a hung handshake ends the run instead of the clock
    task automatic wait_for(ref logic s, input logic v);
        for (n = 0; n < 40 && s !== v; n++) @(negedge clk);
        if (s !== v) begin
            err_total++;
            stop_test();
        end
    endtask
    task automatic boundary(input int lim);
        {got_nmi, got_irq} = 2'h0;
        {core_cycle_end, core_instr_end} = 2'h3;
        for (int k = 0; k < lim && !(got_nmi || got_irq); k++) begin
            @(negedge clk);
            {got_nmi, got_irq} = {nmi_taken === 1'b1, irq_taken === 1'b1};
        end
        {core_cycle_end, core_instr_end} = 2'h0;
    endtask
    initial begin
        {core_cycle_end, core_instr_end, core_pc_inc, core_pc_load, core_ei, core_di} = '0;
        {core_im_set, core_vpage_load, core_refresh_inc, core_m1, core_addr_en} = '0;
        {core_data_en, core_mreq, core_io_request_strobe_n, core_rd, core_wr, rst_n, slow} = '0;
        {core_pc_value, core_addr, core_vpage_value, core_data, core_im_value} = '0;
        {irq_want, nmi_fire, bus_want} = 3'h0;
        repeat (16) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        {core_ei, core_vpage_load, core_im_set, core_refresh_inc, core_pc_load} = 5'h1f;
        {core_vpage_value, core_im_value, core_pc_value} = {8'h5a, 2'h2, 16'h0abc};
        @(negedge clk);
        {core_ei, core_vpage_load, core_im_set, core_refresh_inc, core_pc_load} = 5'h00;
        check({pc, irq_enable_flop, irq_mode, vector_page, refresh_count},
              {16'h0abc, 1'b1, 2'h2, 8'h5a, 8'h01});
        rst_n = 1'b0;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        check({pc, irq_enable_flop, irq_mode, vector_page, refresh_count}, 35'h0);
        check({addr_oe, data_oe, ctrl_oe, mreq_n, io_request_strobe_n, rd_n, wr_n,
               opcode_fetch_cycle_n, bus_release_ack_n}, 9'h03f);
        slow = 4'h5;
        {core_addr_en, core_data_en, core_mreq, core_rd, core_m1, core_pc_load} = 6'h3f;
        {core_addr, core_data, core_pc_value} = {16'hbeef, 8'h3c, 16'h0abc};
        @(negedge clk);
        core_pc_load = 1'b0;
        check({addr_out, data_out, addr_oe, data_oe, mreq_n, rd_n, opcode_fetch_cycle_n},
              {16'hbeef, 8'h3c, 5'h18});
        wait_for(core_stall, 1'b1);
        wait_for(core_stall, 1'b0);
        check(n, 5);
        {core_mreq, core_rd, core_m1, core_ei, slow} = 8'h10;
        @(negedge clk);
        {core_ei, irq_want, nmi_fire, bus_want} = 4'h7;
        boundary(12);
        check({got_nmi, got_irq, bus_release_ack_n, addr_oe, data_oe, ctrl_oe}, 6'h0);
        bus_want = 1'b0;
        boundary(12);
        check({got_nmi, got_irq, pc, push_pc}, {2'h2, 16'h0066, 16'h0abc});
        nmi_fire = 1'b0;
        boundary(8);
        check({got_nmi, got_irq}, 2'h0);
        {core_ei, core_mreq, core_rd} = 3'h7;
        @(negedge clk);
        core_ei = 1'b0;
        boundary(8);
        check({got_nmi, got_irq}, 2'h1);
        wait_for(io_request_strobe_n, 1'b0);
        check({opcode_fetch_cycle_n, mreq_n, rd_n}, 3'h3);
        irq_want = 1'b0;
        core_cycle_end = 1'b1;
        @(negedge clk);
        core_cycle_end = 1'b0;
        wait_for(io_request_strobe_n, 1'b1);
        // io cycle while fetch shows must not raise the io strobe
        {core_mreq, core_rd, core_io_request_strobe_n, core_m1, core_wr, core_pc_inc} = 6'h0f;
        @(negedge clk);
        {core_m1, core_pc_inc} = 2'h0;
        check({io_request_strobe_n, opcode_fetch_cycle_n, wr_n, pc}, {3'h4, 16'h0067});
        @(negedge clk);
        {core_io_request_strobe_n, core_wr} = 2'h0;
        check({io_request_strobe_n, opcode_fetch_cycle_n}, 2'h1);
        stop_test();
    end
endmodule
